// ### edct_top.sv
// Purpose: counter timer with run, stop, up, down, preset and latch commands
// Assumes: pin commands asynchronous; detector commands and control words on clk
// Notes: lane 1 idles while the wide (32-bit) configuration is selected
`timescale 1ns/100ps
module edct_top #(
  parameter int TICK_100US = edct_pkg::TICK_100US_CYC,
  parameter int TICK_1MS = edct_pkg::TICK_1MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,

  // configuration
  input wire logic wide,
  input wire edct_pkg::edct_clk_sel_t clk_sel,
  input wire edct_pkg::edct_cfg_t [edct_pkg::LANES-1:0] cfg,

  // event input terminals, asynchronous pins
  input wire edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] pin_cmd,

  // event detection logic, one-clock pulses or levels on clk
  input wire edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] det_cmd,

  // software run/stop control words
  input wire logic [edct_pkg::LANES-1:0][edct_pkg::CTL_W-1:0] run_halt_control_word,

  // count results
  output logic [edct_pkg::LANES-1:0][edct_pkg::WIDE_W-1:0] count,
  output logic [edct_pkg::LANES-1:0][edct_pkg::WIDE_W-1:0] latch_value,
  output logic [edct_pkg::LANES-1:0] running,

  // status
  output logic overflow,
  output logic underflow,
  output logic [edct_pkg::LANES-1:0] wrapped,
  output edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] cmd_taken,
  output logic tick_seen
);
  typedef struct packed {
    edct_pkg::edct_lane_t [edct_pkg::LANES-1:0] lane;
    logic tick;
  } edct_top_st_t;

  edct_top_st_t st;
  edct_top_st_t next_st;

  logic tick;
  edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] pin_lvl;
  edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] pin_rise;
  edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] merged;
  logic [edct_pkg::LANES-1:0] latch_evt;
  logic [edct_pkg::LANES-1:0] active;

  // widen a stored value to the compare width, honouring lane width and sign
  function automatic logic signed [edct_pkg::EXT_W-1:0] edct_ext(
    input logic [edct_pkg::WIDE_W-1:0] v,
    input logic is_wide,
    input logic sgn
  );
    logic signed [edct_pkg::EXT_W-1:0] r;
    r = '0;
    if (is_wide) begin
      r = sgn ? {{2{v[31]}}, v} : {2'b00, v};
    end else begin
      r = sgn ? {{18{v[15]}}, v[15:0]} : {18'h0_0000, v[15:0]};
    end
    return r;
  endfunction : edct_ext

  // narrow a result back to the lane's stored width
  function automatic logic [edct_pkg::WIDE_W-1:0] edct_fit(
    input logic [edct_pkg::EXT_W-1:0] s,
    input logic is_wide
  );
    return is_wide ? s[31:0] : {16'h0000, s[15:0]};
  endfunction : edct_fit

  edct_tick #(
    .TICK_100US(TICK_100US),
    .TICK_1MS(TICK_1MS)
  ) u_tick (
    .clk(clk),
    .rstn(rstn),
    .sel(clk_sel),
    .tick(tick)
  );

  edct_sync #(
    .WIDTH(edct_pkg::LANES * $bits(edct_pkg::edct_cmd_t))
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .pin(pin_cmd),
    .level(pin_lvl),
    .rise(pin_rise)
  );

  // per-lane command merge
  for (genvar l = 0; l < edct_pkg::LANES; l++) begin : g_lane
    assign merged[l].preset = pin_lvl[l].preset | det_cmd[l].preset; // R10
    assign merged[l].stop = pin_lvl[l].stop | det_cmd[l].stop
                            | run_halt_control_word[l][edct_pkg::CTL_STOP_BIT]; // R10 R16 R17
    assign merged[l].run = pin_lvl[l].run | det_cmd[l].run
                           | run_halt_control_word[l][edct_pkg::CTL_RUN_BIT]; // R10 R16 R17
    assign merged[l].up = pin_lvl[l].up | det_cmd[l].up; // R10
    assign merged[l].down = pin_lvl[l].down | det_cmd[l].down; // R10
    assign merged[l].latch = 1'b0;
    // pin latch counts only on its low-to-high edge
    assign latch_evt[l] = pin_rise[l].latch | det_cmd[l].latch; // R12
    // lane 1 exists only in the narrow configuration
    assign active[l] = (l == 0) || !wide; // R1
  end : g_lane

  logic signed [edct_pkg::EXT_W-1:0] step;
  logic signed [edct_pkg::EXT_W-1:0] delta;
  logic signed [edct_pkg::EXT_W-1:0] sum;
  logic signed [edct_pkg::EXT_W-1:0] hi;
  logic signed [edct_pkg::EXT_W-1:0] lo;
  logic lane_wide;
  logic do_run;
  logic linear_ok;

  always_comb begin
    next_st = st;
    next_st.tick = tick;
    step = '0;
    delta = '0;
    sum = '0;
    hi = '0;
    lo = '0;
    lane_wide = 1'b0;
    do_run = 1'b0;
    linear_ok = 1'b0;
    for (int l = 0; l < edct_pkg::LANES; l++) begin
      lane_wide = wide && (l == 0);
      next_st.lane[l].wrap = 1'b0;
      next_st.lane[l].taken = '0;

      if (active[l] && latch_evt[l]) begin
        next_st.lane[l].latched = st.lane[l].count; // R9
        next_st.lane[l].taken.latch = 1'b1;
      end

      // preset, stop, run, up and down sampled once per counter tick; latch acts on any clock
      if (active[l] && tick && cfg[l].enable) begin // R11 R19
        step = cfg[l].add_mode ? edct_ext(cfg[l].add_value, lane_wide, 1'b0)
                               : $signed(edct_pkg::EXT_ONE);
        hi = edct_ext(cfg[l].upper, lane_wide, cfg[l].signed_mode); // R22
        lo = edct_ext(cfg[l].lower, lane_wide, cfg[l].signed_mode); // R22
        // ring only for 16-bit lanes
        linear_ok = cfg[l].linear && lane_wide; // R2
        do_run = merged[l].run || st.lane[l].run_pend;

        if (merged[l].preset) begin // R13 R14
          next_st.lane[l].taken.preset = 1'b1;
          next_st.lane[l].count = edct_fit(edct_ext(cfg[l].preset_value, lane_wide, 1'b0), lane_wide); // R8
          next_st.lane[l].ovf = 1'b0;
          next_st.lane[l].udf = 1'b0;
          // run hidden behind preset is kept for the next tick
          next_st.lane[l].run_pend = do_run; // R15
          if (cfg[l].preset_stop) begin
            next_st.lane[l].running = 1'b0; // R21
          end
        end else if (merged[l].stop) begin // R13 R14
          next_st.lane[l].taken.stop = 1'b1;
          next_st.lane[l].running = 1'b0;
          next_st.lane[l].run_pend = 1'b0;
          if (cfg[l].stop_preset) begin
            next_st.lane[l].count = edct_fit(edct_ext(cfg[l].preset_value, lane_wide, 1'b0), lane_wide); // R20
            next_st.lane[l].ovf = 1'b0;
            next_st.lane[l].udf = 1'b0;
          end
        end else begin
          delta = '0;
          if (do_run) begin // R14
            next_st.lane[l].taken.run = 1'b1;
            next_st.lane[l].running = 1'b1; // R5
            next_st.lane[l].run_pend = 1'b0;
          end else if (merged[l].up) begin // R13 R14
            next_st.lane[l].taken.up = 1'b1;
            delta = step; // R6
          end else if (merged[l].down) begin // R13 R14
            next_st.lane[l].taken.down = 1'b1;
            delta = -step; // R7
          end
          if (next_st.lane[l].running) begin
            delta = delta + step; // R4
          end

          sum = edct_ext(st.lane[l].count, lane_wide, cfg[l].signed_mode) + delta;
          if (sum > hi) begin
            if (linear_ok) begin
              next_st.lane[l].count = cfg[l].upper; // R24
              next_st.lane[l].ovf = 1'b1; // R3 R24
            end else begin
              next_st.lane[l].count = edct_fit(lo, lane_wide); // R23
              next_st.lane[l].wrap = 1'b1;
            end
          end else if (sum < lo) begin
            if (linear_ok) begin
              next_st.lane[l].count = cfg[l].lower; // R24
              next_st.lane[l].udf = 1'b1; // R3 R24
            end else begin
              next_st.lane[l].count = edct_fit(hi, lane_wide); // R23
              next_st.lane[l].wrap = 1'b1;
            end
          end else begin
            next_st.lane[l].count = edct_fit(sum, lane_wide);
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  for (genvar l = 0; l < edct_pkg::LANES; l++) begin : g_out
    assign count[l] = st.lane[l].count;
    assign latch_value[l] = st.lane[l].latched;
    assign running[l] = st.lane[l].running;
    assign wrapped[l] = st.lane[l].wrap;
    assign cmd_taken[l] = st.lane[l].taken;
  end : g_out

  // overflow and underflow exist for the wide lane only
  assign overflow = st.lane[0].ovf; // R3
  assign underflow = st.lane[0].udf; // R3
  assign tick_seen = st.tick;
endmodule : edct_top

// ### edct_pkg.sv
// Purpose: shared constants and types of the event driven counter timer
// Assumes: one 50 MHz system clock, asynchronous active-low reset
// Notes: constants and carrier types only
// Function
// (R1) two 16-bit lanes or one 32-bit lane
// (R2) 32-bit lane ring or linear; 16-bit ring only
// (R3) 32-bit lane reports overflow and underflow
// (R4) running lane steps once per counter tick
// (R5) run is held until a stop
// (R6) up event adds step or one
// (R7) down event subtracts step or one
// (R8) preset loads the preset value
// (R9) latch copies count, count untouched
// (R10) each command ORs all its sources
// (R11) up, down, preset sampled as levels per tick
// (R12) pin latch acts on rising edge only
// (R13) only the highest priority command acts
// (R14) priority preset, stop, run, up, down
// (R15) run hidden by preset acts next tick
// (R16) control word: bit0 run, bit1 stop
// (R17) control word changes act during operation
// (R18) sources avoid simultaneous commands, stop held high
// (R19) counter tick period selectable, 25ns to 1ms; the 25ns and 50ns selects tick every 40ns and 60ns
// (R20) option: stop also presets
// (R21) option: preset also halts
// (R22) programmable upper and lower limits
// (R23) ring mode wraps to opposite limit
// (R24) linear mode clamps and flags 32-bit lane
package edct_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int LANES = 2;
  localparam int NARROW_W = 16;
  localparam int WIDE_W = 32;
  localparam int EXT_W = 34;
  localparam int CTL_W = 16;
  localparam int CTL_RUN_BIT = 0;
  localparam int CTL_STOP_BIT = 1;
  localparam int SYNC_STAGES = 3;
  localparam int TICK_W = 16;

  // counter tick periods in ns
  localparam int PER_25NS = 25;
  localparam int PER_50NS = 50;
  localparam int PER_100NS = 100;
  localparam int PER_1US = 1000;
  localparam int PER_10US = 10000;
  localparam int PER_100US = 100000;
  localparam int PER_1MS = 1000000;

  // least period, rounded up to whole clocks
  localparam int TICK_25NS_CYC = (PER_25NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_50NS_CYC = (PER_50NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_100NS_CYC = (PER_100NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_1US_CYC = (PER_1US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_10US_CYC = (PER_10US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_100US_CYC = (PER_100US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_1MS_CYC = (PER_1MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [WIDE_W-1:0] COUNT_RST = 32'h0000_0000;
  localparam logic [EXT_W-1:0] EXT_ONE = 34'h0_0000_0001;

  typedef enum logic [2:0] {
    EDCT_CK_25NS = 3'h0,
    EDCT_CK_50NS = 3'h1,
    EDCT_CK_100NS = 3'h2,
    EDCT_CK_1US = 3'h3,
    EDCT_CK_10US = 3'h4,
    EDCT_CK_100US = 3'h5,
    EDCT_CK_1MS = 3'h6
  } edct_clk_sel_t;

  typedef struct packed {
    logic preset;
    logic stop;
    logic run;
    logic up;
    logic down;
    logic latch;
  } edct_cmd_t;

  typedef struct packed {
    logic enable;
    logic linear;
    logic signed_mode;
    logic add_mode;
    logic stop_preset;
    logic preset_stop;
    logic [WIDE_W-1:0] add_value;
    logic [WIDE_W-1:0] upper;
    logic [WIDE_W-1:0] lower;
    logic [WIDE_W-1:0] preset_value;
  } edct_cfg_t;

  typedef struct packed {
    logic [WIDE_W-1:0] count;
    logic [WIDE_W-1:0] latched;
    logic running;
    logic run_pend;
    logic ovf;
    logic udf;
    logic wrap;
    edct_cmd_t taken;
  } edct_lane_t;
endpackage : edct_pkg

// ### edct_tick.sv
// Purpose: counter tick generator with selectable period
// Assumes: select is static or changes rarely
// Notes: tick is a one-clock pulse
`timescale 1ns/100ps
module edct_tick #(
  parameter int TICK_100US = edct_pkg::TICK_100US_CYC,
  parameter int TICK_1MS = edct_pkg::TICK_1MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // period select
  input wire edct_pkg::edct_clk_sel_t sel,
  // tick pulse
  output logic tick
);
  typedef struct packed {
    logic [edct_pkg::TICK_W-1:0] cnt;
    logic tick;
  } edct_tick_st_t;

  edct_tick_st_t st;
  edct_tick_st_t next_st;
  logic [edct_pkg::TICK_W-1:0] limit;

  always_comb begin
    unique case (sel)
      edct_pkg::EDCT_CK_25NS: limit = edct_pkg::TICK_W'(edct_pkg::TICK_25NS_CYC);
      edct_pkg::EDCT_CK_50NS: limit = edct_pkg::TICK_W'(edct_pkg::TICK_50NS_CYC);
      edct_pkg::EDCT_CK_100NS: limit = edct_pkg::TICK_W'(edct_pkg::TICK_100NS_CYC);
      edct_pkg::EDCT_CK_1US: limit = edct_pkg::TICK_W'(edct_pkg::TICK_1US_CYC);
      edct_pkg::EDCT_CK_10US: limit = edct_pkg::TICK_W'(edct_pkg::TICK_10US_CYC);
      edct_pkg::EDCT_CK_100US: limit = edct_pkg::TICK_W'(TICK_100US);
      edct_pkg::EDCT_CK_1MS: limit = edct_pkg::TICK_W'(TICK_1MS);
      default: limit = edct_pkg::TICK_W'(edct_pkg::TICK_25NS_CYC);
    endcase
  end

  // free-running divider, restarts when it reaches limit minus one
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt >= limit - 16'h0001) begin // R19
      next_st.cnt = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule : edct_tick

// ### edct_sync.sv
// Purpose: three-stage synchroniser with agreement filter and rise pulse
// Assumes: inputs asynchronous to clk
// Notes: stage one feeds stage two only
`timescale 1ns/100ps
module edct_sync #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // raw pins
  input wire logic [WIDTH-1:0] pin,
  // filtered level and rising-edge pulse
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
  } edct_sync_st_t;

  edct_sync_st_t st;
  edct_sync_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a change counts once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
      end
    end
    next_st.rise = next_st.level & ~st.level;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
  assign rise = st.rise;
endmodule : edct_sync

// ### edct_checker.sv
// Purpose: port-level checks of the counter timer, lane 0
// Assumes: 25 ns tick select while commands are traced
// Notes: bound from the bench top file
`timescale 1ns/100ps
module edct_checker #(
  parameter int TICK_100US = edct_pkg::TICK_100US_CYC,
  parameter int TICK_1MS = edct_pkg::TICK_1MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration and detector inputs
  input wire logic wide,
  input wire edct_pkg::edct_clk_sel_t clk_sel,
  input wire edct_pkg::edct_cfg_t [edct_pkg::LANES-1:0] cfg,
  input wire edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] det_cmd,
  // results
  input wire logic [edct_pkg::LANES-1:0][edct_pkg::WIDE_W-1:0] count,
  input wire logic [edct_pkg::LANES-1:0][edct_pkg::WIDE_W-1:0] latch_value,
  input wire logic [edct_pkg::LANES-1:0] running,
  input wire logic overflow,
  input wire logic [edct_pkg::LANES-1:0] wrapped,
  input wire edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] cmd_taken,
  input wire logic tick_seen
);
  logic [31:0] step0;
  assign step0 = cfg[0].add_mode ? cfg[0].add_value : 32'h0000_0001;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_preset_with_run;
    cmd_taken[0].preset && $past(det_cmd[0].run) && !$past(det_cmd[0].stop) && cfg[0].enable
      && clk_sel == edct_pkg::EDCT_CK_25NS;
  endsequence
  sequence s_run_next_tick;
    ##2 (cmd_taken[0].run || cmd_taken[0].stop || cmd_taken[0].preset);
  endsequence
  a_prio_one: assert property ($onehot0(cmd_taken[0][5:1]))
    else $error("two commands acted in one tick");
  a_taken_tick: assert property (cmd_taken[0][5:1] != 5'h00 |-> tick_seen)
    else $error("command acted off a tick");
  a_stop_halts: assert property (cmd_taken[0].stop |-> !running[0])
    else $error("stop left the lane running");
  a_run_step: assert property (tick_seen && wide && cfg[0].enable && !cfg[0].linear && $stable(cfg[0])
    && $past(running[0]) && cmd_taken[0][5:1] == 5'h00 && !wrapped[0] |-> count[0] == $past(count[0]) + step0)
    else $error("running step wrong");
  a_preset_load: assert property (cmd_taken[0].preset && wide |-> count[0] == cfg[0].preset_value)
    else $error("preset value not loaded");
  a_stop_load: assert property (cmd_taken[0].stop && cfg[0].stop_preset && wide |-> count[0] == cfg[0].preset_value)
    else $error("stop did not preset");
  a_preset_halt: assert property (cmd_taken[0].preset && cfg[0].preset_stop |-> !running[0])
    else $error("preset did not halt");
  a_wrap_edge: assert property (wrapped[0] && wide |-> count[0] == cfg[0].lower || count[0] == cfg[0].upper)
    else $error("wrap not at a limit");
  a_ovf_clamp: assert property ($rose(overflow) |-> cfg[0].linear && count[0] == cfg[0].upper)
    else $error("overflow without clamp");
  a_latch_copy: assert property (det_cmd[0].latch && det_cmd[0][5:1] == 5'h00 && !running[0]
    |=> latch_value[0] == $past(count[0]))
    else $error("latch copy wrong");
  a_run_after_preset: assert property (s_preset_with_run |-> s_run_next_tick)
    else $error("held run lost after preset");
endmodule : edct_checker

// ### edct_partner.sv
// Purpose: event terminals and edge detectors ahead of the counter
// Assumes: bench requests change just after a clock edge
// Notes: detector latch output is a one-clock rise pulse
`timescale 1ns/100ps
module edct_partner (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // requests from the bench
  input wire edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] req_det,
  input wire edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] req_pin,
  // toward the counter
  output edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] det_cmd,
  output edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] pin_cmd
);
  edct_pkg::edct_cmd_t [edct_pkg::LANES-1:0] prev;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      det_cmd <= '0;
      pin_cmd <= '0;
      prev <= '0;
    end else begin
      for (int i = 0; i < edct_pkg::LANES; i++) begin
        // levels pass, latch becomes a one-clock rise pulse
        det_cmd[i] <= {req_det[i][5:1], req_det[i].latch & ~prev[i].latch};
      end
      prev <= req_det;
      pin_cmd <= req_pin;
    end
  end
endmodule : edct_partner

// ### edct_tb_top.sv
// Purpose: self-checking bench of the counter timer
// Assumes: 25 ns tick select except in the 1 ms gap check, apply holds commands two clocks
// Notes: table rows first, hand tests after
`timescale 1ns/100ps
module edct_tb_top;
  typedef struct packed {
    edct_pkg::edct_cmd_t cmd;
    logic [31:0] exp;
  } edct_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wide = 1'b1;
  edct_pkg::edct_clk_sel_t clk_sel = edct_pkg::EDCT_CK_25NS;
  edct_pkg::edct_cfg_t [1:0] cfg;
  edct_pkg::edct_cmd_t [1:0] req_det = '0;
  edct_pkg::edct_cmd_t [1:0] req_pin = '0;
  edct_pkg::edct_cmd_t [1:0] det_cmd;
  edct_pkg::edct_cmd_t [1:0] pin_cmd;
  edct_pkg::edct_cmd_t [1:0] cmd_taken;
  logic [1:0][15:0] word = '0;
  logic [1:0][31:0] count;
  logic [1:0][31:0] latch_value;
  logic [1:0] running;
  logic [1:0] wrapped;
  logic overflow;
  logic underflow;
  logic tick_seen;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int gap = 0;
  edct_row_t rows[9] = '{'{6'h20, 32'h0000_000A}, '{6'h04, 32'h0000_000D}, '{6'h04, 32'h0000_0010},
    '{6'h26, 32'h0000_000A}, '{6'h06, 32'h0000_000D}, '{6'h14, 32'h0000_000A}, '{6'h02, 32'h0000_0020},
    '{6'h04, 32'h0000_0008}, '{6'h12, 32'h0000_000A}};
  always #10 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  task automatic apply(input int ln, input edct_pkg::edct_cmd_t c);
    req_det[ln] = c;
    cyc(2);
    req_det[ln] = '0;
    cyc(3);
  endtask : apply
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("ERROR %0t: timeout", $time);
      report_and_stop;
    end
  end
  initial begin
    cfg[0] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 32'h0000_0003, 32'h0000_0020, 32'h0000_0008, 32'h0000_000A};
    cfg[1] = cfg[0];
    cyc(2);
    rstn = 1'b1;
    cyc(1);
    for (int i = 0; i < 9; i++) begin
      apply(0, rows[i].cmd);
      chk(count[0], rows[i].exp);
    end
    apply(1, 6'h20);
    chk(count[1], 32'h0000_0000);
    $display("test table done");
    apply(0, 6'h28);
    chk({31'h0, running[0]}, 32'h0000_0001);
    word[0] = 16'h0002;
    cyc(2);
    word[0] = 16'h0000;
    cyc(3);
    chk({31'h0, running[0]}, 32'h0000_0000);
    chk(count[0], 32'h0000_000A);
    word[0] = 16'h0001;
    cyc(2);
    word[0] = 16'h0000;
    cyc(6);
    chk({31'h0, running[0]}, 32'h0000_0001);
    req_pin[0].stop = 1'b1;
    cyc(8);
    req_pin[0].stop = 1'b0;
    cyc(6);
    chk({31'h0, running[0]}, 32'h0000_0000);
    $display("test run_stop done");
    apply(0, 6'h01);
    chk(latch_value[0], 32'h0000_000A);
    chk(count[0], 32'h0000_000A);
    apply(0, 6'h04);
    req_pin[0].latch = 1'b1;
    cyc(8);
    apply(0, 6'h04);
    chk(latch_value[0], 32'h0000_000D);
    chk(count[0], 32'h0000_0010);
    req_pin[0].latch = 1'b0;
    $display("test latch done");
    cfg[0].linear = 1'b1;
    cfg[0].preset_value = 32'h0000_001F;
    apply(0, 6'h20);
    apply(0, 6'h04);
    chk(count[0], 32'h0000_0020);
    chk({31'h0, overflow}, 32'h0000_0001);
    cfg[0].preset_value = 32'h0000_0009;
    apply(0, 6'h20);
    chk({31'h0, overflow}, 32'h0000_0000);
    apply(0, 6'h02);
    chk(count[0], 32'h0000_0008);
    chk({31'h0, underflow}, 32'h0000_0001);
    $display("test linear done");
    wide = 1'b0;
    cfg[1].preset_value = 32'h0000_0009;
    cfg[1].linear = 1'b1;
    apply(1, 6'h20);
    apply(1, 6'h02);
    chk(count[1], 32'h0000_0020);
    chk(count[0], 32'h0000_0008);
    $display("test narrow done");
    cfg[1].add_mode = 1'b0;
    apply(1, 6'h20);
    req_det[1].up = 1'b1;
    cyc(8);
    req_det[1].up = 1'b0;
    cyc(3);
    chk(count[1], 32'h0000_000D);
    cfg[1].signed_mode = 1'b1;
    cfg[1].upper = 32'h0000_0007;
    cfg[1].lower = 32'h0000_FFF8;
    cfg[1].preset_value = 32'h0000_0000;
    apply(1, 6'h20);
    apply(1, 6'h02);
    chk(count[1], 32'h0000_FFFF);
    cfg[1].preset_stop = 1'b0;
    word[1] = 16'h0001;
    cyc(2);
    word[1] = 16'h0000;
    apply(1, 6'h20);
    chk({31'h0, running[1]}, 32'h0000_0001);
    clk_sel = edct_pkg::EDCT_CK_1MS;
    cyc(3);
    while (!tick_seen) begin
      cyc(1);
    end
    gap = 0;
    do begin
      cyc(1);
      gap++;
    end while (!tick_seen);
    chk(gap, 32'h0000_0009);
    clk_sel = edct_pkg::EDCT_CK_25NS;
    cyc(3);
    $display("test options done");
    rstn = 1'b0;
    cyc(1);
    chk(count[0] | count[1] | latch_value[0] | latch_value[1], 32'h0000_0000);
    chk({30'h0, running}, 32'h0000_0000);
    rstn = 1'b1;
    cyc(2);
    $display("test reset done");
    report_and_stop;
  end
  edct_partner i_partner (.clk(clk), .rstn(rstn), .req_det(req_det), .req_pin(req_pin), .det_cmd(det_cmd),
    .pin_cmd(pin_cmd));
  edct_top #(.TICK_100US(7), .TICK_1MS(9)) i_dut (.clk(clk), .rstn(rstn), .wide(wide), .clk_sel(clk_sel),
    .cfg(cfg), .pin_cmd(pin_cmd), .det_cmd(det_cmd), .run_halt_control_word(word), .count(count),
    .latch_value(latch_value), .running(running), .overflow(overflow), .underflow(underflow),
    .wrapped(wrapped), .cmd_taken(cmd_taken), .tick_seen(tick_seen));
endmodule : edct_tb_top
bind edct_top edct_checker #(.TICK_100US(TICK_100US), .TICK_1MS(TICK_1MS)) i_chk (.clk(clk), .rstn(rstn),
  .wide(wide), .clk_sel(clk_sel), .cfg(cfg), .det_cmd(det_cmd), .count(count), .latch_value(latch_value),
  .running(running), .overflow(overflow), .wrapped(wrapped), .cmd_taken(cmd_taken), .tick_seen(tick_seen));
